//--- core/usbctl_pkg.sv
// Shared constants and types of the USB module control block
package usbctl_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_STAT = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_MASK = 8'h08;
	localparam int unsigned BIT_JSTATE = 7;
	localparam int unsigned BIT_SE0 = 6;
	localparam int unsigned BIT_PKT = 5;
	localparam int unsigned BIT_BUSRST = 4;
	localparam int unsigned BIT_HOST = 3;
	localparam int unsigned BIT_RESUME = 2;
	localparam int unsigned BIT_PPCLR = 1;
	localparam int unsigned BIT_EN = 0;
	localparam int unsigned CTRL_W = 8;
	localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
	localparam int unsigned EV_W = 4;
	localparam int unsigned EV_SETUP = 0;
	localparam int unsigned EV_TOKDONE = 1;
	localparam int unsigned EV_SE0 = 2;
	localparam int unsigned EV_HOSTCHG = 3;
	localparam logic [EV_W-1:0] EV_RST = 4'h0;
	localparam int unsigned CLK_NS = 100;
	localparam int unsigned LS_BIT_NS = 667;
	localparam int unsigned EOP_SE0_BITS = 2;
	localparam int unsigned EOP_J_BITS = 1;
	localparam int unsigned EOP_SE0_CYC = (EOP_SE0_BITS * LS_BIT_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned EOP_J_CYC = (EOP_J_BITS * LS_BIT_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned CNT_W = 5;
	typedef enum logic [1:0] {EOP_IDLE, EOP_SE0, EOP_J} usbctl_eop_t;
endpackage

//--- core/usbctl_sync.sv
// Two-flop level synchroniser
module usbctl_sync #(
	parameter int unsigned WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_reg;

	// First stage feeds the second stage only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule // usbctl_sync

//--- core/usbctl_top.sv
// USB module control register, live bus flags and resume sequencer
// Functional notes
// - Control bits 31 to 8 read zero.
// - Bit 7 shows live J state.
// - Bit 6 shows live single-ended zero.
// - Function mode: bit 5 stops packet processing.
// - Function mode: SETUP token sets bit 5 automatically.
// - Host mode: bit 5 shows token executing.
// - Host mode: bit 4 drives bus reset.
// - Bit 3 enables host, resets to zero.
// - Host enable change resets host logic.
// - Bit 2 drives resume signalling.
// - Host resume clear appends low-speed EOP.
module usbctl_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [usbctl_pkg::ADDR_W-1:0] paddr,
	input wire logic [usbctl_pkg::DATA_W-1:0] pwdata,
	output logic [usbctl_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic bus_j_state,
	input wire logic bus_se0,
	input wire logic setup_token_rx,
	input wire logic token_active,
	output logic packet_processing_off,
	output logic bus_reset_drive,
	output logic host_capability_on,
	output logic resume_drive,
	output logic eop_se0_drive,
	output logic eop_j_drive,
	output logic host_logic_reset,
	output logic pingpong_pointer_clear,
	output logic function_module_on,
	output logic frame_marker_on,
	output logic irq
);
	logic [1:0] live_raw;
	logic [1:0] live_sync;
	logic j_live;
	logic se0_live;
	logic se0_prev_reg;
	logic setup_ph;
	logic access_ph;
	logic hit_ctrl;
	logic hit_stat;
	logic hit_mask;
	logic ctrl_wr;
	logic stat_wr;
	logic mask_wr;
	logic host_chg;
	logic pkt_dis_reg;
	logic bus_rst_reg;
	logic host_reg;
	logic resume_reg;
	logic ppclr_reg;
	logic en_reg;
	logic tok_busy_reg;
	logic [usbctl_pkg::CTRL_W-1:0] ctrl_view;
	logic [usbctl_pkg::DATA_W-1:0] rd_mux;
	logic [usbctl_pkg::EV_W-1:0] ev;
	logic [usbctl_pkg::EV_W-1:0] status_reg;
	logic [usbctl_pkg::EV_W-1:0] status_next;
	logic [usbctl_pkg::EV_W-1:0] mask_reg;
	logic eop_start;
	usbctl_pkg::usbctl_eop_t eop_reg;
	usbctl_pkg::usbctl_eop_t eop_next;
	logic [usbctl_pkg::CNT_W-1:0] eop_cnt_reg;
	logic [usbctl_pkg::CNT_W-1:0] eop_cnt_next;

	// Bus lines are asynchronous to pclk
	assign live_raw = {bus_j_state, bus_se0};

	usbctl_sync #(
		.WIDTH(2)
	) u_live_sync (
		.clk(pclk),
		.rst_n(presetn),
		.d(live_raw),
		.q(live_sync)
	);

	assign j_live = live_sync[1];
	assign se0_live = live_sync[0];

	// APB decode; zero wait states
	assign setup_ph = psel && !penable;
	assign access_ph = psel && penable && pready;
	assign hit_ctrl = (paddr == usbctl_pkg::OFF_CTRL);
	assign hit_stat = (paddr == usbctl_pkg::OFF_STAT);
	assign hit_mask = (paddr == usbctl_pkg::OFF_MASK);
	assign ctrl_wr = access_ph && pwrite && hit_ctrl;
	assign stat_wr = access_ph && pwrite && hit_stat;
	assign mask_wr = access_ph && pwrite && hit_mask;
	assign host_chg = ctrl_wr && (pwdata[usbctl_pkg::BIT_HOST] != host_reg);

	always_comb begin
		ctrl_view = usbctl_pkg::CTRL_RST;
		ctrl_view[usbctl_pkg::BIT_JSTATE] = j_live;
		ctrl_view[usbctl_pkg::BIT_SE0] = se0_live;
		ctrl_view[usbctl_pkg::BIT_PKT] = host_reg ? tok_busy_reg : pkt_dis_reg;
		ctrl_view[usbctl_pkg::BIT_BUSRST] = bus_rst_reg;
		ctrl_view[usbctl_pkg::BIT_HOST] = host_reg;
		ctrl_view[usbctl_pkg::BIT_RESUME] = resume_reg;
		ctrl_view[usbctl_pkg::BIT_PPCLR] = ppclr_reg;
		ctrl_view[usbctl_pkg::BIT_EN] = en_reg;
	end

	always_comb begin
		rd_mux = '0;
		if (hit_ctrl) begin
			rd_mux[usbctl_pkg::CTRL_W-1:0] = ctrl_view;
		end else if (hit_stat) begin
			rd_mux[usbctl_pkg::EV_W-1:0] = status_reg;
		end else if (hit_mask) begin
			rd_mux[usbctl_pkg::EV_W-1:0] = mask_reg;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= setup_ph;
			pslverr <= setup_ph && !(hit_ctrl || hit_stat || hit_mask);
			prdata <= (setup_ph && !pwrite) ? rd_mux : '0;
		end
	end

	// Set by hardware wins over a software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pkt_dis_reg <= 1'b0;
		end else if (setup_token_rx && !host_reg) begin
			pkt_dis_reg <= 1'b1;
		end else if (ctrl_wr && !host_reg) begin
			pkt_dis_reg <= pwdata[usbctl_pkg::BIT_PKT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_rst_reg <= 1'b0;
			host_reg <= 1'b0;
			resume_reg <= 1'b0;
			ppclr_reg <= 1'b0;
			en_reg <= 1'b0;
		end else if (ctrl_wr) begin
			bus_rst_reg <= pwdata[usbctl_pkg::BIT_BUSRST];
			host_reg <= pwdata[usbctl_pkg::BIT_HOST];
			resume_reg <= pwdata[usbctl_pkg::BIT_RESUME];
			ppclr_reg <= pwdata[usbctl_pkg::BIT_PPCLR];
			en_reg <= pwdata[usbctl_pkg::BIT_EN];
		end
	end

	// Busy flag drops with a host-enable change
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tok_busy_reg <= 1'b0;
		end else begin
			tok_busy_reg <= token_active && host_reg && !host_chg;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			packet_processing_off <= 1'b0;
			bus_reset_drive <= 1'b0;
			host_capability_on <= 1'b0;
			resume_drive <= 1'b0;
			pingpong_pointer_clear <= 1'b0;
			function_module_on <= 1'b0;
			frame_marker_on <= 1'b0;
			host_logic_reset <= 1'b0;
		end else begin
			packet_processing_off <= pkt_dis_reg && !host_reg;
			bus_reset_drive <= bus_rst_reg && host_reg;
			host_capability_on <= host_reg;
			resume_drive <= resume_reg;
			pingpong_pointer_clear <= ppclr_reg;
			function_module_on <= en_reg && !host_reg;
			frame_marker_on <= en_reg && host_reg;
			host_logic_reset <= host_chg;
		end
	end

	// EOP tail after host resume; a host toggle aborts it
	assign eop_start = ctrl_wr && host_reg && resume_reg && !pwdata[usbctl_pkg::BIT_RESUME] && !host_chg;

	always_comb begin
		eop_next = eop_reg;
		eop_cnt_next = eop_cnt_reg;
		if (host_chg) begin
			eop_next = usbctl_pkg::EOP_IDLE;
			eop_cnt_next = '0;
		end else begin
			case (eop_reg)
				usbctl_pkg::EOP_IDLE: begin
					if (eop_start) begin
						eop_next = usbctl_pkg::EOP_SE0;
						eop_cnt_next = usbctl_pkg::CNT_W'(usbctl_pkg::EOP_SE0_CYC - 1);
					end
				end
				usbctl_pkg::EOP_SE0: begin
					if (eop_cnt_reg == '0) begin
						eop_next = usbctl_pkg::EOP_J;
						eop_cnt_next = usbctl_pkg::CNT_W'(usbctl_pkg::EOP_J_CYC - 1);
					end else begin
						eop_cnt_next = eop_cnt_reg - 1'b1;
					end
				end
				usbctl_pkg::EOP_J: begin
					if (eop_cnt_reg == '0) begin
						eop_next = usbctl_pkg::EOP_IDLE;
					end else begin
						eop_cnt_next = eop_cnt_reg - 1'b1;
					end
				end
				default: begin
					eop_next = usbctl_pkg::EOP_IDLE;
					eop_cnt_next = '0;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eop_reg <= usbctl_pkg::EOP_IDLE;
			eop_cnt_reg <= '0;
			eop_se0_drive <= 1'b0;
			eop_j_drive <= 1'b0;
		end else begin
			eop_reg <= eop_next;
			eop_cnt_reg <= eop_cnt_next;
			eop_se0_drive <= (eop_next == usbctl_pkg::EOP_SE0);
			eop_j_drive <= (eop_next == usbctl_pkg::EOP_J);
		end
	end

	// Sticky events, write one to clear
	always_comb begin
		ev = '0;
		ev[usbctl_pkg::EV_SETUP] = setup_token_rx && !host_reg;
		ev[usbctl_pkg::EV_TOKDONE] = tok_busy_reg && !token_active && host_reg && !host_chg;
		ev[usbctl_pkg::EV_SE0] = se0_live && !se0_prev_reg;
		ev[usbctl_pkg::EV_HOSTCHG] = host_chg;
		status_next = status_reg;
		if (stat_wr) begin
			status_next = status_reg & ~pwdata[usbctl_pkg::EV_W-1:0];
		end
		status_next = status_next | ev;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			se0_prev_reg <= 1'b0;
			status_reg <= usbctl_pkg::EV_RST;
			mask_reg <= usbctl_pkg::EV_RST;
			irq <= 1'b0;
		end else begin
			se0_prev_reg <= se0_live;
			status_reg <= status_next;
			if (mask_wr) begin
				mask_reg <= pwdata[usbctl_pkg::EV_W-1:0];
			end
			irq <= |(status_reg & mask_reg);
		end
	end

	// Helper run length of the EOP SE0 phase
	logic [usbctl_pkg::CNT_W-1:0] se0_run_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			se0_run_reg <= '0;
		end else if (eop_se0_drive) begin
			se0_run_reg <= se0_run_reg + 1'b1;
		end else begin
			se0_run_reg <= '0;
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_ctrl_read;
		psel && !penable && !pwrite && paddr == usbctl_pkg::OFF_CTRL;
	endsequence

	sequence s_ctrl_write;
		psel && penable && pready && pwrite && paddr == usbctl_pkg::OFF_CTRL;
	endsequence

	sequence s_resume_release;
		s_ctrl_write ##0 host_reg && resume_reg && pwdata[usbctl_pkg::BIT_HOST]
			&& !pwdata[usbctl_pkg::BIT_RESUME];
	endsequence

	a_upper_zero: assert property (pready |-> prdata[31:8] == '0)
		else $error("upper control bits not zero");

	a_jstate_sync: assert property (##2 1 |-> j_live == $past(bus_j_state, 2))
		else $error("J flag not two-cycle synchronised");

	a_se0_sync: assert property (##2 1 |-> se0_live == $past(bus_se0, 2))
		else $error("SE0 flag not two-cycle synchronised");

	a_pkt_stop: assert property (pkt_dis_reg && !host_reg |=> packet_processing_off)
		else $error("packet processing not stopped");

	a_setup_sets: assert property (setup_token_rx && !host_reg |=> pkt_dis_reg)
		else $error("SETUP did not set packet disable");

	a_token_read: assert property (s_ctrl_read ##0 host_reg |=> prdata[usbctl_pkg::BIT_PKT] == $past(tok_busy_reg))
		else $error("token busy not shown in host mode");

	a_bus_reset: assert property (s_ctrl_write ##0 pwdata[usbctl_pkg::BIT_BUSRST] && pwdata[usbctl_pkg::BIT_HOST]
		&& host_reg |=> ##1 bus_reset_drive)
		else $error("bus reset not driven");

	a_host_toggle: assert property ($changed(host_reg) |-> host_logic_reset && eop_reg == usbctl_pkg::EOP_IDLE)
		else $error("host change did not reset host logic");

	a_resume_drive: assert property ($rose(resume_reg) |=> resume_drive)
		else $error("resume not driven");

	a_eop_start: assert property (s_resume_release |=> eop_se0_drive [*8])
		else $error("EOP SE0 phase missing or short");

	a_eop_length: assert property ($fell(eop_se0_drive) && !host_logic_reset
		|-> eop_j_drive && se0_run_reg == usbctl_pkg::EOP_SE0_CYC)
		else $error("EOP SE0 phase length wrong");

	a_irq_level: assert property (|(status_reg & mask_reg) |=> irq)
		else $error("interrupt not raised");
endmodule // usbctl_top

//--- sim/testbench.sv
// Self-checking bench of the USB module control block
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic [1:0] line_cmd = 2'h0;
	logic setup_cmd = 1'b0, tok_cmd = 1'b0, er;
	logic pready, pslverr, bus_j_state, bus_se0, setup_token_rx, token_active, packet_processing_off;
	logic bus_reset_drive, host_capability_on, resume_drive, eop_se0_drive, eop_j_drive, host_logic_reset;
	logic pingpong_pointer_clear, function_module_on, frame_marker_on, irq;
	logic [6:0] ov;
	int n_errors = 0, checks_done = 0, n_hlr = 0, n_se0 = 0, n_j = 0, k, h0, s0, j0;
	// Write value, read back, outputs {pkt, busrst, host, resume, ppclr, fon, fmon}
	logic [70:0] rows [7] = '{{32'h1, 32'h81, 7'h02}, {32'h2, 32'h82, 7'h04}, {32'h4, 32'h84, 7'h08},
		{32'h10, 32'h90, 7'h00}, {32'h20, 32'hA0, 7'h40}, {32'hFFFFFF37, 32'hB7, 7'h4E}, {32'h0, 32'h80, 7'h00}};
	assign ov = {packet_processing_off, bus_reset_drive, host_capability_on, resume_drive,
		pingpong_pointer_clear, function_module_on, frame_marker_on};
	usbctl_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.bus_j_state, .bus_se0, .setup_token_rx, .token_active, .packet_processing_off, .bus_reset_drive,
		.host_capability_on, .resume_drive, .eop_se0_drive, .eop_j_drive, .host_logic_reset,
		.pingpong_pointer_clear, .function_module_on, .frame_marker_on, .irq);
	usbctl_bus_model bus_u (.pclk, .presetn, .line_cmd, .setup_cmd, .tok_cmd, .bus_j_state, .bus_se0,
		.setup_token_rx, .token_active);
	initial begin
		forever #50 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (host_logic_reset === 1'b1) n_hlr++;
		if (eop_se0_drive === 1'b1) n_se0++;
		if (eop_j_drive === 1'b1) n_j++;
	end
	task automatic give_verdict;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// Edge first, so release and next setup never land in one time step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a stuck access
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk("prdata", e, r);
	endtask
	task automatic pulse_setup;
		setup_cmd <= 1'b1;
		@(posedge pclk);
		setup_cmd <= 1'b0;
	endtask
	initial begin
		#500000;
		n_errors++;
		give_verdict();
	end
	initial begin
		cyc(6);
		presetn <= 1'b1;
		chk("outs", 32'h0, 32'(ov));
		// Live flags need two edges after release
		cyc(2);
		chk("outs", 32'h0, 32'(ov));
		rd(8'h00, 32'h80);
		line_cmd <= 2'h2;
		cyc(3);
		rd(8'h00, 32'h40);
		line_cmd <= 2'h1;
		cyc(3);
		rd(8'h00, 32'h00);
		line_cmd <= 2'h0;
		for (int i = 0; i < 7; i++) begin
			wr(8'h00, rows[i][70:39]);
			rd(8'h00, rows[i][38:7]);
			chk("outs", 32'(rows[i][6:0]), 32'(ov));
		end
		wr(8'h00, 32'h1);
		pulse_setup();
		cyc(2);
		chk("pkt off", 32'h1, 32'(packet_processing_off));
		rd(8'h00, 32'hA1);
		chk("irq masked", 32'h0, 32'(irq));
		rd(8'h04, 32'h5);
		wr(8'h08, 32'h1);
		cyc(2);
		chk("irq", 32'h1, 32'(irq));
		wr(8'h04, 32'h1);
		cyc(2);
		chk("irq cleared", 32'h0, 32'(irq));
		h0 = n_hlr;
		wr(8'h00, 32'h09);
		cyc(2);
		chk("host reset", 32'(h0 + 1), 32'(n_hlr));
		chk("outs", 32'h11, 32'(ov));
		wr(8'h00, 32'h29);
		pulse_setup();
		cyc(2);
		rd(8'h00, 32'h89);
		chk("outs", 32'h11, 32'(ov));
		tok_cmd <= 1'b1;
		@(posedge pclk);
		tok_cmd <= 1'b0;
		rd(8'h00, 32'hA9);
		k = 0;
		do begin
			apb(1'b0, 8'h00, 32'h0);
			k++;
		end while (r[5] !== 1'b0 && k < 20);
		chk("token idle", 32'h0, 32'(r[5]));
		rd(8'h04, 32'h0E);
		wr(8'h00, 32'h19);
		cyc(2);
		chk("bus reset", 32'h1, 32'(bus_reset_drive));
		wr(8'h00, 32'h09);
		cyc(2);
		chk("bus reset", 32'h0, 32'(bus_reset_drive));
		wr(8'h00, 32'h0D);
		cyc(2);
		chk("resume", 32'h1, 32'(resume_drive));
		// Held far shorter than real software would, to keep the run brief
		cyc(20);
		s0 = n_se0;
		j0 = n_j;
		wr(8'h00, 32'h09);
		cyc(30);
		chk("eop se0", usbctl_pkg::EOP_SE0_CYC, 32'(n_se0 - s0));
		chk("eop j", usbctl_pkg::EOP_J_CYC, 32'(n_j - j0));
		chk("resume", 32'h0, 32'(resume_drive));
		wr(8'h0C, 32'hFFFFFFFF);
		chk("pslverr", 32'h1, 32'(er));
		rd(8'h0C, 32'h0);
		chk("pslverr", 32'h1, 32'(er));
		h0 = n_hlr;
		wr(8'h00, 32'h0);
		cyc(2);
		chk("host reset", 32'(h0 + 1), 32'(n_hlr));
		give_verdict();
	end
endmodule // testbench

//--- sim/usbctl_bus_model.sv
// Behavioural USB bus partner: line state, SETUP tokens and token execution
module usbctl_bus_model #(
	parameter int unsigned TOK_CYC = 6
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [1:0] line_cmd,
	input wire logic setup_cmd,
	input wire logic tok_cmd,
	output logic bus_j_state,
	output logic bus_se0,
	output logic setup_token_rx,
	output logic token_active
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] tok_cnt;
	// Line code 0 idle J, 1 K, 2 single-ended zero; never both flags at once
	assign bus_j_state = (line_cmd == 2'h0);
	assign bus_se0 = (line_cmd == 2'h2);
	assign setup_token_rx = setup_cmd;
	// Token lasts several cycles so software really sees it busy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tok_cnt <= 4'h0;
		else if (tok_cmd)
			tok_cnt <= 4'(TOK_CYC);
		else if (tok_cnt != 4'h0)
			tok_cnt <= tok_cnt - 4'h1;
	end
	assign token_active = (tok_cnt != 4'h0);
endmodule // usbctl_bus_model
